// [logic/dinsel_top.sv]
// dinsel_top: terminal function decoder with apb register access
`timescale 1ns/1ps
// Operation
// - terminal code 40 enables torque limit
// - codes 41,42 pick one of four limits
// - code 44 reports brake confirmation
// - code 46 bypasses ramp timing
// - code 47 clears positioning pulse count
// - code 50 applies offset to setpoint
// - config bit chooses add or subtract
// - offset works for any setpoint source
// - code 51 forces terminal frequency and run
// - released force restores configured sources
// - code 51 source change while running stops first
// - code 52 permits torque command input
// - any code assignable to any terminal
module dinsel_top
  import dinsel_pkg::*;
(
  input  wire logic                i_clk,
  input  wire logic                i_reset,
  input  wire logic                i_psel,
  input  wire logic                i_penable,
  input  wire logic                i_pwrite,
  input  wire logic [7:0]          i_paddr,
  input  wire logic [31:0]         i_pwdata,
  output logic      [31:0]         o_prdata,
  output logic                     o_pready,
  output logic                     o_pslverr,
  input  wire logic [NUM_TERM-1:0] i_term,
  input  wire logic [FREQ_W-1:0]   i_cfg_setpoint,
  input  wire logic [FREQ_W-1:0]   i_term_setpoint,
  input  wire logic                i_motor_running,
  output dinsel_func_t             o_func,
  output logic      [TLIM_W-1:0]   o_tlim_value,
  output logic      [FREQ_W-1:0]   o_setpoint,
  output dinsel_src_t              o_src,
  output logic                     o_stop_req
);

  logic [NUM_TERM-1:0]              term_q;
  logic [NUM_TERM-1:0][CODE_W-1:0]  assign_q;
  logic [3:0][TLIM_W-1:0]           tlim_q;
  logic [FREQ_W-1:0]                offset_q;
  logic [5:0]                       ctrl_q;
  dinsel_func_t                     func_d;
  dinsel_state_t                    state_q;
  logic                             force_eff_q;
  logic                             apb_acc;
  logic                             apb_wr;
  logic [FREQ_W-1:0]                base_sp;
  logic [FREQ_W-1:0]                sp_d;

  // true when any terminal carrying this code is active
  function automatic logic fn_on(
    input logic [NUM_TERM-1:0]             lvl,
    input logic [NUM_TERM-1:0][CODE_W-1:0] codes,
    input logic [CODE_W-1:0]               code
  );
    logic hit;
    hit = 1'b0;
    for (int t = 0; t < NUM_TERM; t++) begin
      hit = hit | (lvl[t] & (codes[t] == code));
    end
    return hit;
  endfunction : fn_on

  // saturating offset so the setpoint never wraps
  function automatic logic [FREQ_W-1:0] offset_sp(
    input logic [FREQ_W-1:0] sp,
    input logic [FREQ_W-1:0] off,
    input logic              sub
  );
    logic [FREQ_W:0] sum;
    sum = '0;
    if (sub) begin
      sum = (sp >= off) ? {1'b0, sp - off} : '0;
    end else begin
      sum = {1'b0, sp} + {1'b0, off};
      if (sum[FREQ_W]) begin
        sum = {1'b0, {FREQ_W{1'b1}}};
      end
    end
    return sum[FREQ_W-1:0];
  endfunction : offset_sp

  // terminal sampling
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      term_q <= '0;
    end else begin
      term_q <= i_term;
    end
  end

  always_comb begin
    func_d             = '0;
    func_d.lim_en      = fn_on(term_q, assign_q, CODE_LIM_EN);
    func_d.lim_sel0    = fn_on(term_q, assign_q, CODE_LIM_SEL0);
    func_d.lim_sel1    = fn_on(term_q, assign_q, CODE_LIM_SEL1);
    func_d.brake_ok    = fn_on(term_q, assign_q, CODE_BRAKE);
    func_d.ramp_bypass = fn_on(term_q, assign_q, CODE_RAMP);
    func_d.pulse_clr   = fn_on(term_q, assign_q, CODE_PULSE_CLR);
    func_d.offset_on   = fn_on(term_q, assign_q, CODE_ADD);
    func_d.force_term  = fn_on(term_q, assign_q, CODE_FORCE);
    func_d.trq_permit  = fn_on(term_q, assign_q, CODE_PERMIT);
  end

  // source selection; the offset is applied after it, whichever source
  always_comb begin
    base_sp = force_eff_q ? i_term_setpoint : i_cfg_setpoint;
    sp_d    = base_sp;
    if (func_d.offset_on) begin
      sp_d = offset_sp(base_sp, offset_q, ctrl_q[CTRL_SUB_BIT]);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_func       <= '0;
      o_tlim_value <= TLIM_RST;
      o_setpoint   <= '0;
    end else begin
      o_func       <= func_d;
      o_tlim_value <= tlim_q[{func_d.lim_sel1, func_d.lim_sel0}];
      o_setpoint   <= sp_d;
    end
  end

  // force changeover: a change while running waits for the motor to stop
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_q     <= DINSEL_APPLIED;
      force_eff_q <= 1'b0;
      o_stop_req  <= 1'b0;
    end else begin
      case (state_q)
        DINSEL_APPLIED: begin
          if (func_d.force_term != force_eff_q) begin
            if (i_motor_running) begin
              state_q    <= DINSEL_STOPPING;
              o_stop_req <= 1'b1;
            end else begin
              force_eff_q <= func_d.force_term;
            end
          end
        end
        DINSEL_STOPPING: begin
          if (!i_motor_running) begin
            // take the level present now, it may have flipped back
            force_eff_q <= func_d.force_term;
            o_stop_req  <= 1'b0;
            state_q     <= DINSEL_APPLIED;
          end
        end
        default: state_q <= DINSEL_APPLIED;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_src <= '0;
    end else if (force_eff_q) begin
      o_src.freq_src <= FREQ_SRC_TERM;
      o_src.run_src  <= RUN_SRC_TERM;
    end else begin
      o_src.freq_src <= ctrl_q[CTRL_FSRC_LSB +: 3];
      o_src.run_src  <= ctrl_q[CTRL_RSRC_LSB +: 2];
    end
  end

  // apb slave: one wait state, answer with pready on the second access cycle
  assign apb_acc = i_psel & i_penable;
  assign apb_wr  = apb_acc & o_pready & i_pwrite;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_pready  <= 1'b0;
      o_prdata  <= '0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= apb_acc & ~o_pready;
      o_prdata  <= '0;
      o_pslverr <= 1'b0;
      if (apb_acc & ~o_pready) begin
        if (i_paddr == ADDR_ASSIGN_LO) begin
          o_prdata <= {assign_q[3], assign_q[2], assign_q[1], assign_q[0]};
        end else if (i_paddr == ADDR_ASSIGN_HI) begin
          o_prdata <= {8'h00, assign_q[6], assign_q[5], assign_q[4]};
        end else if (i_paddr == ADDR_TLIM01) begin
          o_prdata <= {tlim_q[1], tlim_q[0]};
        end else if (i_paddr == ADDR_TLIM23) begin
          o_prdata <= {tlim_q[3], tlim_q[2]};
        end else if (i_paddr == ADDR_OFFSET) begin
          o_prdata <= {16'h0000, offset_q};
        end else if (i_paddr == ADDR_CTRL) begin
          o_prdata <= {26'h0000000, ctrl_q};
        end else if (i_paddr == ADDR_STATUS) begin
          o_prdata <= {21'h000000, o_stop_req, force_eff_q, o_func};
        end else begin
          o_pslverr <= 1'b1;
        end
      end
    end
  end

  // writes land on the edge that sees pready high; status is read only
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      assign_q <= {NUM_TERM{ASSIGN_RST}};
      tlim_q   <= {4{TLIM_RST}};
      offset_q <= OFFSET_RST;
      ctrl_q   <= CTRL_RST;
    end else if (apb_wr) begin
      if (i_paddr == ADDR_ASSIGN_LO) begin
        assign_q[3:0] <= i_pwdata;
      end else if (i_paddr == ADDR_ASSIGN_HI) begin
        assign_q[6:4] <= i_pwdata[23:0];
      end else if (i_paddr == ADDR_TLIM01) begin
        tlim_q[1:0] <= i_pwdata;
      end else if (i_paddr == ADDR_TLIM23) begin
        tlim_q[3:2] <= i_pwdata;
      end else if (i_paddr == ADDR_OFFSET) begin
        offset_q <= i_pwdata[15:0];
      end else if (i_paddr == ADDR_CTRL) begin
        ctrl_q <= i_pwdata[5:0];
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  chk_term_sample: assert property (
    ##1 term_q == $past(i_term))
    else $error("terminal sample lags more than one cycle");

  chk_limit_enable: assert property (
    fn_on(term_q, assign_q, CODE_LIM_EN) |=> o_func.lim_en)
    else $error("torque limit enable not applied");

  chk_limit_select: assert property (
    ##1 o_tlim_value == $past(tlim_q[{func_d.lim_sel1, func_d.lim_sel0}]))
    else $error("wrong torque limit selected");

  chk_brake_level: assert property (
    fn_on(term_q, assign_q, CODE_BRAKE) |=> o_func.brake_ok)
    else $error("brake confirmation not reported");

  chk_torque_permit: assert property (
    !fn_on(term_q, assign_q, CODE_PERMIT) |=> !o_func.trq_permit)
    else $error("torque command permitted without its input");

  chk_ramp_bypass: assert property (
    !fn_on(term_q, assign_q, CODE_RAMP) |=> !o_func.ramp_bypass)
    else $error("ramp bypass without its input");

  chk_pulse_clear: assert property (
    fn_on(term_q, assign_q, CODE_PULSE_CLR) != o_func.pulse_clr
    |-> $changed(term_q) || $changed(assign_q) || $past(i_reset))
    else $error("pulse clear does not follow its input");

  chk_offset_pass: assert property (
    !func_d.offset_on |=> o_setpoint == $past(base_sp))
    else $error("setpoint modified while offset off");

  chk_offset_sub: assert property (
    func_d.offset_on && ctrl_q[CTRL_SUB_BIT] && base_sp >= offset_q
    |=> o_setpoint == $past(base_sp) - $past(offset_q))
    else $error("offset not subtracted");

  chk_force_src: assert property (
    force_eff_q |=> o_src.freq_src == FREQ_SRC_TERM
                    && o_src.run_src == RUN_SRC_TERM)
    else $error("forced terminal sources not applied");

  chk_src_revert: assert property (
    !force_eff_q |=> o_src.run_src == $past(ctrl_q[CTRL_RSRC_LSB +: 2]))
    else $error("configured run source not restored");

  chk_no_run_switch: assert property (
    $changed(force_eff_q) |-> !$past(i_motor_running))
    else $error("source changed while motor running");

  chk_stop_first: assert property (
    state_q == DINSEL_APPLIED && func_d.force_term != force_eff_q
    && i_motor_running |=> o_stop_req ##0 $stable(force_eff_q))
    else $error("no stop request before changeover");

  chk_apb_ready: assert property (
    apb_acc && !o_pready |=> o_pready ##1 !o_pready)
    else $error("apb answer not one wait state");

  chk_apb_refuse: assert property (
    apb_acc && !o_pready && i_paddr > ADDR_STATUS |=> o_pslverr)
    else $error("unmapped address not refused");

  cov_force_while_run: cover property (
    o_stop_req ##1 !o_stop_req && $changed(force_eff_q));
  cov_offset_add: cover property (
    func_d.offset_on && !ctrl_q[CTRL_SUB_BIT]);
  cov_apb_write: cover property (apb_wr);
  cov_limit_three: cover property (func_d.lim_sel1 && func_d.lim_sel0);

endmodule : dinsel_top

// [include/dinsel_pkg.sv]
// dinsel_pkg: constants, register map and carrier types of the input selector
package dinsel_pkg;
  localparam int          NUM_TERM       = 7;
  localparam int          CODE_W         = 8;
  localparam int          FREQ_W         = 16;
  localparam int          TLIM_W         = 16;
  // terminal function codes
  localparam logic [7:0]  CODE_LIM_EN    = 8'h28; // 40
  localparam logic [7:0]  CODE_LIM_SEL0  = 8'h29; // 41
  localparam logic [7:0]  CODE_LIM_SEL1  = 8'h2a; // 42
  localparam logic [7:0]  CODE_BRAKE     = 8'h2c; // 44
  localparam logic [7:0]  CODE_RAMP      = 8'h2e; // 46
  localparam logic [7:0]  CODE_PULSE_CLR = 8'h2f; // 47
  localparam logic [7:0]  CODE_ADD       = 8'h32; // 50
  localparam logic [7:0]  CODE_FORCE     = 8'h33; // 51
  localparam logic [7:0]  CODE_PERMIT    = 8'h34; // 52
  // source selections meaning "control terminals"
  localparam logic [2:0]  FREQ_SRC_TERM  = 3'h1;
  localparam logic [1:0]  RUN_SRC_TERM   = 2'h1;
  // apb register byte offsets
  localparam logic [7:0]  ADDR_ASSIGN_LO = 8'h00;
  localparam logic [7:0]  ADDR_ASSIGN_HI = 8'h04;
  localparam logic [7:0]  ADDR_TLIM01    = 8'h08;
  localparam logic [7:0]  ADDR_TLIM23    = 8'h0c;
  localparam logic [7:0]  ADDR_OFFSET    = 8'h10;
  localparam logic [7:0]  ADDR_CTRL      = 8'h14;
  localparam logic [7:0]  ADDR_STATUS    = 8'h18;
  // control register fields
  localparam int          CTRL_SUB_BIT   = 0;
  localparam int          CTRL_FSRC_LSB  = 1;
  localparam int          CTRL_RSRC_LSB  = 4;
  // reset values
  localparam logic [7:0]  ASSIGN_RST     = 8'h00;
  localparam logic [15:0] TLIM_RST       = 16'hffff;
  localparam logic [15:0] OFFSET_RST     = 16'h0000;
  localparam logic [5:0]  CTRL_RST       = 6'h00;

  typedef struct packed {
    logic lim_en;
    logic lim_sel1;
    logic lim_sel0;
    logic brake_ok;
    logic ramp_bypass;
    logic pulse_clr;
    logic offset_on;
    logic force_term;
    logic trq_permit;
  } dinsel_func_t;

  typedef struct packed {
    logic [2:0] freq_src;
    logic [1:0] run_src;
  } dinsel_src_t;

  typedef enum logic {DINSEL_APPLIED, DINSEL_STOPPING} dinsel_state_t;
endpackage : dinsel_pkg

// [verification/dinsel_contacts.sv]
// dinsel_contacts: switch contacts and motor state seen by the selector
`timescale 1ns/1ps
module dinsel_contacts
  import dinsel_pkg::*;
(
  input  wire logic                i_clk,
  input  wire logic [NUM_TERM-1:0] i_close,
  input  wire logic                i_spin,
  output logic      [NUM_TERM-1:0] o_term,
  output logic                     o_running
);
  // contacts move only at an edge, like a debounced input card
  always_ff @(posedge i_clk) begin
    o_term    <= i_close;
    o_running <= i_spin;
  end
endmodule : dinsel_contacts

// [verification/drive_input_function_selector_test.sv]
// drive_input_function_selector_test: self-checking bench for dinsel_top
`timescale 1ns/1ps
module drive_input_function_selector_test
  import dinsel_pkg::*;
;
  logic         clk, rst, psel, pen, pwr, rdy, err, rerr, run, spin, stop;
  logic [7:0]   addr;
  logic [31:0]  wdat, rdat, rd;
  logic [6:0]   term, close;
  logic [15:0]  cfg_sp, term_sp, tlim, sp;
  logic [5:0]   ctrl;
  dinsel_func_t func;
  dinsel_src_t  src;
  int           miscompares, comparisons, feff, estop, off, v, t;
  int           ecode[7];
  int           lims[4];
  int           list[9] = '{40, 41, 42, 44, 46, 47, 50, 51, 52};

  dinsel_contacts u_dinsel_contacts (.i_clk(clk), .i_close(close),
    .i_spin(spin), .o_term(term), .o_running(run));
  dinsel_top u_dinsel_top (.i_clk(clk), .i_reset(rst), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdat),
    .o_prdata(rdat), .o_pready(rdy), .o_pslverr(err), .i_term(term),
    .i_cfg_setpoint(cfg_sp), .i_term_setpoint(term_sp),
    .i_motor_running(run), .o_func(func), .o_tlim_value(tlim),
    .o_setpoint(sp), .o_src(src), .o_stop_req(stop));

  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end

  task automatic stop_test();
    if (miscompares == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // holds the request until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pen  <= 0;
    pwr  <= w;
    addr <= a;
    wdat <= d;
    @(posedge clk);
    pen <= 1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge clk);
    end while (rdy !== 1'b1);
    rd   = rdat;
    rerr = err;
    psel <= 0;
    pen  <= 0;
  endtask : apb

  task automatic set_codes();
    apb(1, ADDR_ASSIGN_LO, {ecode[3][7:0], ecode[2][7:0],
                            ecode[1][7:0], ecode[0][7:0]});
    apb(1, ADDR_ASSIGN_HI, {8'h00, ecode[6][7:0], ecode[5][7:0],
                            ecode[4][7:0]});
  endtask : set_codes

  // several terminals on one code are ORed
  function automatic dinsel_func_t mfunc(input logic [6:0] l);
    dinsel_func_t f;
    f = '0;
    for (int i = 0; i < 7; i++) begin
      if (l[i]) begin
        case (ecode[i])
          40: f.lim_en = 1;
          41: f.lim_sel0 = 1;
          42: f.lim_sel1 = 1;
          44: f.brake_ok = 1;
          46: f.ramp_bypass = 1;
          47: f.pulse_clr = 1;
          50: f.offset_on = 1;
          51: f.force_term = 1;
          52: f.trq_permit = 1;
          default: ;
        endcase
      end
    end
    return f;
  endfunction : mfunc

  function automatic int msp(input dinsel_func_t f);
    int b;
    b = feff ? int'(term_sp) : int'(cfg_sp);
    if (f.offset_on) b = ctrl[0] ? b - off : b + off;
    return b < 0 ? 0 : (b > 65535 ? 65535 : b);
  endfunction : msp

  // outputs settle two edges after the contacts (three for src and setpoint when the force code changes), plus the contact flop
  task automatic check_all();
    dinsel_func_t f;
    repeat (5) @(posedge clk);
    #1;
    f = mfunc(close);
    chk("func", f, func);
    chk("tlim", lims[{f.lim_sel1, f.lim_sel0}], tlim);
    chk("setpoint", msp(f), sp);
    chk("src", feff ? {3'h1, 2'h1} : {ctrl[3:1], ctrl[5:4]}, src);
    chk("stop", estop, stop);
  endtask : check_all

  initial begin
    #(30000 * 8);
    miscompares++;
    stop_test();
  end

  initial begin
    rst = 1; psel = 0; pen = 0; pwr = 0; addr = 0; wdat = 0; close = 0;
    spin = 0; cfg_sp = 0; term_sp = 0; ctrl = 0; feff = 0; estop = 0;
    off = 0; miscompares = 0; comparisons = 0;
    foreach (ecode[i]) ecode[i] = 0;
    foreach (lims[i]) lims[i] = 16'hffff;
    void'($urandom(2));
    repeat (2) @(posedge clk);
    rst <= 0;
    apb(0, ADDR_TLIM23, 0);
    chk("tlim23_reset", 32'hffffffff, rd);
    apb(1, 8'h1c, 32'h1234);
    chk("unmapped_err", 1, rerr);
    foreach (lims[i]) lims[i] = $urandom_range(65535);
    apb(1, ADDR_TLIM01, {lims[1][15:0], lims[0][15:0]});
    apb(1, ADDR_TLIM23, {lims[3][15:0], lims[2][15:0]});
    // every function code on a random terminal
    for (int k = 0; k < 9; k++) begin
      foreach (ecode[i]) ecode[i] = 0;
      t = $urandom_range(6);
      ecode[t] = list[k];
      set_codes();
      v = $urandom;
      close   <= v[6:0];
      cfg_sp  <= $urandom;
      term_sp <= $urandom;
      feff = v[t] && list[k] == 51;
      check_all();
    end
    // limit selector and offset in both directions, saturation included
    foreach (ecode[i]) ecode[i] = 0;
    ecode[0] = 41;
    ecode[1] = 42;
    ecode[2] = 50;
    set_codes();
    feff = 0;
    off = 16'hc000;
    apb(1, ADDR_OFFSET, off);
    for (int s = 0; s < 2; s++) begin
      ctrl = {2'($urandom), 3'($urandom), s[0]};
      apb(1, ADDR_CTRL, {26'h0, ctrl});
      apb(0, ADDR_CTRL, 0);
      chk("ctrl_rd", {26'h0, ctrl}, rd);
      for (int i = 0; i < 8; i++) begin
        close  <= i[6:0];
        cfg_sp <= $urandom;
        check_all();
      end
    end
    // forced sources while running wait for the stop
    foreach (ecode[i]) ecode[i] = 0;
    ecode[3] = 51;
    set_codes();
    close <= 0;
    spin  <= 1;
    check_all();
    close <= 7'h08;
    estop = 1;
    check_all();
    spin <= 0;
    estop = 0;
    feff = 1;
    check_all();
    close <= 0;
    feff = 0;
    check_all();
    stop_test();
  end
endmodule : drive_input_function_selector_test
